// File: rtl/pcg_regs.svh
// constants for the peripheral bus clock gating block
// assumes a byte-wide register port with small word addresses
`ifndef PCG_REGS_SVH
`define PCG_REGS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define PCG_SERIAL_CONV_OFS 4'h0
`define PCG_MISC_PERIPH_OFS 4'h1
`define PCG_PORT_OFS 4'h2

// ----------------------------------------------------------------------
// reset values: every clock passes after reset
// ----------------------------------------------------------------------
`define PCG_SERIAL_CONV_RST 8'hFF
`define PCG_MISC_PERIPH_RST 8'hBF
`define PCG_PORT_RST 8'hFF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PCG_CONV_B_BIT 7
`define PCG_CONV_A_BIT 6
`define PCG_KEYPAD_BIT 5
`define PCG_TWO_WIRE_BIT 4
`define PCG_CLKOUT_DIV_BIT 7
`define PCG_MISC_RSVD_BIT 6
`define PCG_VREF_BIT 5
`define PCG_EXT_IRQ_BIT 4
`define PCG_DISPLAY_BIT 3
`define PCG_PORT_E_BIT 4
// writable bits of the misc register; bit 6 is reserved
`define PCG_MISC_WMASK 8'hBF

`endif

// File: rtl/pcg_pkg.sv
// types for the peripheral bus clock gating block
// assumes pcg_regs.svh is available on the include path
package pcg_pkg;

    // ------------------------------------------------------------------
    // register port request
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pcg_req_t;

    // ------------------------------------------------------------------
    // gate enables, one per peripheral clock
    // ------------------------------------------------------------------
    typedef struct packed {
        logic converter_b_gate;
        logic converter_a_gate;
        logic keypad_interrupt_gate;
        logic two_wire_gate;
        logic [3:0] uart_gate;
        logic clock_out_divider_gate;
        logic vref_gate;
        logic ext_irq_gate;
        logic display_driver_gate;
        logic [2:0] serial_periph_gate;
        logic [7:0] port_gate;
    } pcg_gates_t;

endpackage

// File: rtl/pcg_top.sv
// peripheral bus clock gating: three gating registers and gated clocks
// assumes a plain register port synchronous to ref_clk_i
`timescale 1ns/1ps
`include "pcg_regs.svh"

// Summary of operation
// - first register bit 7 passes or blocks the second converter clock.
// - first register bit 6 passes or blocks the first converter clock.
// - first register bit 5 gates the keyboard interrupt clock.
// - first register bit 4 gates the two-wire bus clock.
// - first register bits 3..0 gate serial channels three down to zero.
// - second register bit 7 gates the clock-output prescaler clock.
// - second register bit 5 gates the voltage reference clock.
// - second register bit 4 gates both external interrupt units.
// - second register bit 3 gates the display driver clock.
// - second register bits 2..0 gate serial peripheral channels two to zero.
// - third register bits 7,6,5 gate ports H, G and F.
// - third register bit 4 gates both port E units together.
// - third register bits 3..0 gate ports D, C, B and A.
module pcg_top
    import pcg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output pcg_gates_t gates_o,
    output logic converter_b_clk_o,
    output logic converter_a_clk_o,
    output logic keypad_interrupt_clk_o,
    output logic two_wire_clk_o,
    output logic [3:0] uart_clk_o,
    output logic clock_out_divider_clk_o,
    output logic vref_clk_o,
    output logic ext_irq_clk_o,
    output logic display_driver_clk_o,
    output logic [2:0] serial_periph_clk_o,
    output logic [7:0] port_clk_o
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    pcg_req_t req;
    logic [7:0] serial_conv_q, serial_conv_d;
    logic [7:0] misc_periph_q, misc_periph_d;
    logic [7:0] port_q, port_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] en_serial_q, en_misc_q, en_port_q;

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i,
                   wr: reg_wr_i, rd: reg_rd_i};

    // next values: writes land, reads are captured for the next cycle
    always_comb begin
        serial_conv_d = serial_conv_q;
        misc_periph_d = misc_periph_q;
        port_d = port_q;
        rdata_d = 8'h00;
        if (req.wr) begin
            case (req.addr)
                `PCG_SERIAL_CONV_OFS: serial_conv_d = req.wdata;
                // reserved bit masked off on write
                `PCG_MISC_PERIPH_OFS:
                    misc_periph_d = req.wdata & `PCG_MISC_WMASK;
                `PCG_PORT_OFS: port_d = req.wdata;
                default: ;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                `PCG_SERIAL_CONV_OFS: rdata_d = serial_conv_q;
                `PCG_MISC_PERIPH_OFS: rdata_d = misc_periph_q;
                `PCG_PORT_OFS: rdata_d = port_q;
                default: rdata_d = 8'h00; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            serial_conv_q <= `PCG_SERIAL_CONV_RST;
            misc_periph_q <= `PCG_MISC_PERIPH_RST;
            port_q <= `PCG_PORT_RST;
            rdata_q <= 8'h00;
        end else begin
            serial_conv_q <= serial_conv_d;
            misc_periph_q <= misc_periph_d;
            port_q <= port_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;

    // ------------------------------------------------------------------
    // glitch-free gating: enables latched while the clock is low
    // ------------------------------------------------------------------
    // a latch transparent on low clock keeps each gated pulse whole
    // when software flips a bit mid-cycle
    always_latch begin
        if (!ref_clk_i) begin
            en_serial_q <= serial_conv_q;
            en_misc_q <= misc_periph_q;
            en_port_q <= port_q;
        end
    end

    // ------------------------------------------------------------------
    // gate map, reflected as register-driven enables
    // ------------------------------------------------------------------
    always_comb begin
        gates_o.converter_b_gate = serial_conv_q[`PCG_CONV_B_BIT];
        gates_o.converter_a_gate = serial_conv_q[`PCG_CONV_A_BIT];
        gates_o.keypad_interrupt_gate =
            serial_conv_q[`PCG_KEYPAD_BIT];
        gates_o.two_wire_gate = serial_conv_q[`PCG_TWO_WIRE_BIT];
        gates_o.uart_gate = serial_conv_q[3:0];
        gates_o.clock_out_divider_gate =
            misc_periph_q[`PCG_CLKOUT_DIV_BIT];
        gates_o.vref_gate = misc_periph_q[`PCG_VREF_BIT];
        gates_o.ext_irq_gate = misc_periph_q[`PCG_EXT_IRQ_BIT];
        gates_o.display_driver_gate =
            misc_periph_q[`PCG_DISPLAY_BIT];
        gates_o.serial_periph_gate = misc_periph_q[2:0];
        gates_o.port_gate = port_q;
    end

    // gated clocks: bus clock anded with the latched enable
    assign converter_b_clk_o =
        ref_clk_i & en_serial_q[`PCG_CONV_B_BIT];
    assign converter_a_clk_o =
        ref_clk_i & en_serial_q[`PCG_CONV_A_BIT];
    assign keypad_interrupt_clk_o =
        ref_clk_i & en_serial_q[`PCG_KEYPAD_BIT];
    assign two_wire_clk_o =
        ref_clk_i & en_serial_q[`PCG_TWO_WIRE_BIT];
    assign uart_clk_o = {4{ref_clk_i}} & en_serial_q[3:0];
    assign clock_out_divider_clk_o =
        ref_clk_i & en_misc_q[`PCG_CLKOUT_DIV_BIT];
    assign vref_clk_o = ref_clk_i & en_misc_q[`PCG_VREF_BIT];
    // one enable feeds both external interrupt units
    assign ext_irq_clk_o = ref_clk_i & en_misc_q[`PCG_EXT_IRQ_BIT];
    assign display_driver_clk_o =
        ref_clk_i & en_misc_q[`PCG_DISPLAY_BIT];
    assign serial_periph_clk_o =
        {3{ref_clk_i}} & en_misc_q[2:0];
    // bit 4 drives both port E units from the same output
    assign port_clk_o = {8{ref_clk_i}} & en_port_q;

endmodule

// File: tb/pcg_chk.sv
// assertions on the ports of the clock gating block
// assumes the gate layout of pcg_pkg; bound onto pcg_top below
`timescale 1ns/1ps
module pcg_chk
    import pcg_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire pcg_gates_t gates_o,
    input wire logic ext_irq_clk_o,
    input wire logic [7:0] port_clk_o
);
    // ------------------------------------------------------------------
    // register port and gate relations
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    conv_gates_a:
    assert property (reg_wr_i && reg_addr_i == 4'h0 |=>
        gates_o[22:15] == $past(reg_wdata_i)) else $error("conv gates");
    misc_gates_a:
    assert property (reg_wr_i && reg_addr_i == 4'h1 |=> gates_o[14:8] ==
        {$past(reg_wdata_i[7]), $past(reg_wdata_i[5:0])}) else $error("misc");
    port_gates_a:
    assert property (reg_wr_i && reg_addr_i == 4'h2 |=>
        gates_o.port_gate == $past(reg_wdata_i)) else $error("port gates");
    gates_hold_a:
    assert property (!reg_wr_i |=> $stable(gates_o)) else $error("gates move");
    rsvd_zero_a:
    assert property (reg_rd_i && reg_addr_i == 4'h1 |=> !reg_rdata_o[6])
        else $error("reserved bit set");
    read_idle_a:
    assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("rdata");
    port_read_a:
    assert property (reg_rd_i && reg_addr_i == 4'h2 |=>
        reg_rdata_o == gates_o.port_gate) else $error("port readback");
    // gated clocks follow the enable held over the preceding low phase
    port_clk_a:
    assert property (@(negedge ref_clk_i) disable iff (!arst_n_i)
        port_clk_o == $past(gates_o.port_gate)) else $error("port clock");
    irq_clk_a:
    assert property (@(negedge ref_clk_i) disable iff (!arst_n_i)
        ext_irq_clk_o == $past(gates_o.ext_irq_gate)) else $error("irq clk");
endmodule
bind pcg_top pcg_chk u_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .gates_o(gates_o),
    .ext_irq_clk_o(ext_irq_clk_o), .port_clk_o(port_clk_o));

// File: tb/tb_peripheral_bus_clock_gating.sv
// self-checking bench for the clock gating block
// assumes pcg_top, its package and the checker are compiled alongside
`timescale 1ns/1ps
`include "pcg_regs.svh"
module tb_peripheral_bus_clock_gating;
    import pcg_pkg::*;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    // every gated clock, packed in the same order as the gate struct
    wire [22:0] clks;
    pcg_gates_t gates;
    logic [7:0] shadow [3];
    int n_errors = 0;
    int n_checks = 0;
    pcg_top u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .gates_o(gates),
        .converter_b_clk_o(clks[22]), .converter_a_clk_o(clks[21]),
        .keypad_interrupt_clk_o(clks[20]), .two_wire_clk_o(clks[19]),
        .uart_clk_o(clks[18:15]), .clock_out_divider_clk_o(clks[14]),
        .vref_clk_o(clks[13]), .ext_irq_clk_o(clks[12]),
        .display_driver_clk_o(clks[11]), .serial_periph_clk_o(clks[10:8]),
        .port_clk_o(clks[7:0]));
    // ------------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------------
    initial begin
        forever #10 ref_clk_i = ~ref_clk_i;
    end
    task automatic bus(input logic w, input logic r, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge ref_clk_i);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
    endtask
    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // expected gate levels rebuilt from the written register images
    function automatic logic [22:0] exp_gates();
        return {shadow[0], shadow[1][7], shadow[1][5:0], shadow[2]};
    endfunction
    // optional write, then a read of the same place with no gap
    task automatic access(input logic w, input logic [3:0] a,
                          input logic [7:0] d);
        logic [7:0] exp;
        if (w && a < 4'h3) begin
            shadow[a[1:0]] = (a == 4'h1) ? (d & `PCG_MISC_WMASK) : d;
        end
        if (w) begin
            bus(1'b1, 1'b0, a, d);
        end
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        exp = (a < 4'h3) ? shadow[a[1:0]] : 8'h00;
        #1;
        chk(23'(rdata), 23'(exp));
        chk(gates, exp_gates());
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_walk();
        for (int a = 0; a < 3; a++) begin
            for (int i = 0; i < 8; i++) begin
                access(1'b1, 4'(a), 8'h01 << i);
                // nothing sits behind the gates, so no re-init
                access(1'b1, 4'(a), ~(8'h01 << i));
            end
        end
        $display("walking gates done");
    endtask
    // unmapped writes must leave every gate alone
    task automatic t_unmapped();
        access(1'b1, 4'h3, 8'h00);
        access(1'b1, 4'hF, 8'h00);
        $display("unmapped done");
    endtask
    // all gated clocks high only in high phases, and only where enabled;
    // no peripheral runs here, so clearing gate bits is safe
    task automatic t_clocks();
        access(1'b1, 4'h0, 8'hA5);
        access(1'b1, 4'h1, 8'h96);
        access(1'b1, 4'h2, 8'h5A);
        @(posedge ref_clk_i);
        #5 chk(clks, exp_gates());
        @(negedge ref_clk_i);
        #5 chk(clks, 23'h00_0000);
        $display("clocks done");
    endtask
    task automatic t_reset();
        // reset is asserted on a rising edge, like every other input
        @(posedge ref_clk_i);
        arst_n_i <= 1'b0;
        shadow = '{`PCG_SERIAL_CONV_RST, `PCG_MISC_PERIPH_RST, `PCG_PORT_RST};
        repeat (3) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            access(1'b0, 4'(a), 8'h00);
        end
        $display("reset done");
    endtask
    initial begin
        repeat (5000) @(posedge ref_clk_i);
        n_errors++;
        stop_test();
    end
    initial begin
        t_reset();
        t_walk();
        t_unmapped();
        t_clocks();
        t_reset();
        stop_test();
    end
endmodule
